// ---- shared/isp_consts.vh ----
// Shared constants of the in-system programming test port
`ifndef ISP_CONSTS_VH
`define ISP_CONSTS_VH

`define IR_W 4
`define IR_CAPTURE 4'h1
`define OP_IDCODE 4'h1
`define OP_ENABLE 4'h9
`define OP_ERASE 4'hA
`define OP_PROGRAM 4'hB
`define OP_VERIFY 4'hC
`define OP_BYPASS 4'hF
`define ID_W 32
`define BYPASS_CAPTURE 1'h0

// Waits that the programming controller keeps; the device does not time them
`define BULK_CLEAR_MIN_DURATION_MS 100
`define ROW_WRITE_MIN_DURATION_MS 10
`define ROW_READBACK_MIN_DURATION_US 10
`define INIT_MIN_DURATION_US 100
`define TCK_MAX_FREQ_MHZ 10

`endif

// ---- core/row_mem.v ----
// Nonvolatile row array model with bulk clear and registered read data
`timescale 1ns/10ps
module row_mem #(
    parameter ADDR_W = 6,
    parameter DATA_W = 32
) (
    // Clock and reset
    input wire clk_i,
    input wire srst_i,
    // Commands
    input wire clear_i,
    input wire wr_i,
    input wire rd_i,
    input wire [ADDR_W-1:0] addr_i,
    input wire [DATA_W-1:0] wdata_i,
    // Read data
    output reg [DATA_W-1:0] rdata_o
);
    localparam DEPTH = 1 << ADDR_W;

    reg [DATA_W-1:0] cells [0:DEPTH-1];
    // Contents and written flags survive reset, as the cells are nonvolatile
    reg [DEPTH-1:0] written_reg;

    always @(posedge clk_i) begin
        if (clear_i) begin
            written_reg <= {DEPTH{1'b0}};
        end else if (wr_i) begin
            written_reg[addr_i] <= 1'b1;
        end
        if (wr_i) begin
            cells[addr_i] <= wdata_i;
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= {DATA_W{1'b0}};
        end else if (rd_i) begin
            rdata_o <= written_reg[addr_i] ? cells[addr_i] : {DATA_W{1'b0}};
        end
    end
endmodule

// ---- core/isp_tap.v ----
// Test access port with in-system programming commands for the row array
//
// Behaviour
// - Erase, program and verify ignored until unlock loaded; unlock then persists until test reset.
// - Code 1001 arms erase, program, verify and selects the row chain.
// - Code 1010 while armed clears the entire array at once.
// - Code 1011 while armed writes chain data into the addressed row.
// - Code 1100 while armed copies the addressed row into the chain.
// - Programming runs only through the test port; no external supply needed.
// - TMS low leaves reset toward test mode; pulled high when idle.
// - TDI sampled on TCK rise, TDO changes on fall, released otherwise.
// - Code 1111 places one-bit bypass between TDI and TDO.
// - Code 0001 shifts the identification word out.
`timescale 1ns/10ps
`include "isp_consts.vh"
module isp_tap #(
    parameter ADDR_W = 6,
    parameter ROW_W = 32,
    // Arbitrary identification value; bit 0 is one as the scan standard asks
    parameter [`ID_W-1:0] ID_CODE = 32'h0ABC_D001
) (
    // Clock and reset
    input wire clk_i,
    input wire srst_i,
    // Test port pins
    input wire tck_i,
    input wire tms_i,
    input wire tdi_i,
    output reg tdo_o,
    output reg tdo_oe_n_o,
    // Status
    output reg armed_o,
    output reg test_mode_o
);
    localparam CHAIN_W = ADDR_W + ROW_W;

    localparam [15:0] ST_TLR = 16'h0001;
    localparam [15:0] ST_RTI = 16'h0002;
    localparam [15:0] ST_SELDR = 16'h0004;
    localparam [15:0] ST_CAPDR = 16'h0008;
    localparam [15:0] ST_SHDR = 16'h0010;
    localparam [15:0] ST_EX1DR = 16'h0020;
    localparam [15:0] ST_PADR = 16'h0040;
    localparam [15:0] ST_EX2DR = 16'h0080;
    localparam [15:0] ST_UPDR = 16'h0100;
    localparam [15:0] ST_SELIR = 16'h0200;
    localparam [15:0] ST_CAPIR = 16'h0400;
    localparam [15:0] ST_SHIR = 16'h0800;
    localparam [15:0] ST_EX1IR = 16'h1000;
    localparam [15:0] ST_PAIR = 16'h2000;
    localparam [15:0] ST_EX2IR = 16'h4000;
    localparam [15:0] ST_UPIR = 16'h8000;

    localparam [1:0] SEL_BYPASS = 2'h0;
    localparam [1:0] SEL_ID = 2'h1;
    localparam [1:0] SEL_CHAIN = 2'h2;

    // Standard controller walk; five TMS highs reach reset from any state
    function [15:0] tap_next;
        input [15:0] s;
        input t;
        begin
            case (s)
                ST_TLR: tap_next = t ? ST_TLR : ST_RTI;
                ST_RTI: tap_next = t ? ST_SELDR : ST_RTI;
                ST_SELDR: tap_next = t ? ST_SELIR : ST_CAPDR;
                ST_CAPDR: tap_next = t ? ST_EX1DR : ST_SHDR;
                ST_SHDR: tap_next = t ? ST_EX1DR : ST_SHDR;
                ST_EX1DR: tap_next = t ? ST_UPDR : ST_PADR;
                ST_PADR: tap_next = t ? ST_EX2DR : ST_PADR;
                ST_EX2DR: tap_next = t ? ST_UPDR : ST_SHDR;
                ST_UPDR: tap_next = t ? ST_SELDR : ST_RTI;
                ST_SELIR: tap_next = t ? ST_TLR : ST_CAPIR;
                ST_CAPIR: tap_next = t ? ST_EX1IR : ST_SHIR;
                ST_SHIR: tap_next = t ? ST_EX1IR : ST_SHIR;
                ST_EX1IR: tap_next = t ? ST_UPIR : ST_PAIR;
                ST_PAIR: tap_next = t ? ST_EX2IR : ST_PAIR;
                ST_EX2IR: tap_next = t ? ST_UPIR : ST_SHIR;
                ST_UPIR: tap_next = t ? ST_SELDR : ST_RTI;
                default: tap_next = ST_TLR;
            endcase
        end
    endfunction

    // Data register selected by an instruction code
    function [1:0] dr_select;
        input [`IR_W-1:0] code;
        begin
            case (code)
                `OP_IDCODE: dr_select = SEL_ID;
                `OP_ENABLE: dr_select = SEL_CHAIN;
                `OP_ERASE: dr_select = SEL_CHAIN;
                `OP_PROGRAM: dr_select = SEL_CHAIN;
                `OP_VERIFY: dr_select = SEL_CHAIN;
                default: dr_select = SEL_BYPASS;
            endcase
        end
    endfunction

    // Pin synchronisers; the third stage only serves edge detection of TCK
    reg tck_s1_reg, tck_s2_reg, tck_s3_reg;
    reg tms_s1_reg, tms_s2_reg;
    reg tdi_s1_reg, tdi_s2_reg;

    always @(posedge clk_i) begin
        if (srst_i) begin
            tck_s1_reg <= 1'b0;
            tck_s2_reg <= 1'b0;
            tck_s3_reg <= 1'b0;
            tms_s1_reg <= 1'b1;
            tms_s2_reg <= 1'b1;
            tdi_s1_reg <= 1'b1;
            tdi_s2_reg <= 1'b1;
        end else begin
            tck_s1_reg <= tck_i;
            tck_s2_reg <= tck_s1_reg;
            tck_s3_reg <= tck_s2_reg;
            tms_s1_reg <= tms_i;
            tms_s2_reg <= tms_s1_reg;
            tdi_s1_reg <= tdi_i;
            tdi_s2_reg <= tdi_s1_reg;
        end
    end

    wire tck_rise = tck_s2_reg & ~tck_s3_reg;
    wire tck_fall = ~tck_s2_reg & tck_s3_reg;

    reg [15:0] state_reg;
    reg [`IR_W-1:0] ir_reg;
    reg [`IR_W-1:0] ir_shift_reg;
    reg bypass_reg;
    reg [`ID_W-1:0] id_shift_reg;
    reg [CHAIN_W-1:0] chain_reg;
    reg armed_reg;
    reg clear_reg, wr_reg, rd_reg, load_reg;
    wire [ROW_W-1:0] row_rdata;

    wire [1:0] sel = dr_select(ir_reg);
    wire [ADDR_W-1:0] row_addr = chain_reg[CHAIN_W-1:ROW_W];

    always @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= ST_TLR;
            ir_reg <= `OP_IDCODE;
            ir_shift_reg <= `IR_CAPTURE;
            bypass_reg <= `BYPASS_CAPTURE;
            id_shift_reg <= ID_CODE;
            armed_reg <= 1'b0;
            clear_reg <= 1'b0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
        end else begin
            clear_reg <= 1'b0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            if (tck_rise) begin
                state_reg <= tap_next(state_reg, tms_s2_reg);
                case (state_reg)
                    ST_TLR: begin
                        ir_reg <= `OP_IDCODE;
                        armed_reg <= 1'b0;
                    end
                    ST_CAPIR: ir_shift_reg <= `IR_CAPTURE;
                    ST_SHIR: ir_shift_reg <= {tdi_s2_reg, ir_shift_reg[`IR_W-1:1]};
                    ST_UPIR: begin
                        ir_reg <= ir_shift_reg;
                        // Armed state is sampled before this update, so unlock
                        // must come in an earlier instruction than the operation
                        if (ir_shift_reg == `OP_ENABLE) begin
                            armed_reg <= 1'b1;
                        end
                        clear_reg <= armed_reg && (ir_shift_reg == `OP_ERASE);
                        wr_reg <= armed_reg && (ir_shift_reg == `OP_PROGRAM);
                        rd_reg <= armed_reg && (ir_shift_reg == `OP_VERIFY);
                    end
                    ST_CAPDR: begin
                        bypass_reg <= `BYPASS_CAPTURE;
                        id_shift_reg <= ID_CODE;
                    end
                    ST_SHDR: begin
                        if (sel == SEL_BYPASS) begin
                            bypass_reg <= tdi_s2_reg;
                        end
                        if (sel == SEL_ID) begin
                            id_shift_reg <= {tdi_s2_reg, id_shift_reg[`ID_W-1:1]};
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Row chain: shifted by the port, reloaded by a readback one cycle after
    // the array read; a readback wins over a shift landing in the same cycle
    always @(posedge clk_i) begin
        if (srst_i) begin
            chain_reg <= {CHAIN_W{1'b0}};
            load_reg <= 1'b0;
        end else begin
            load_reg <= rd_reg;
            if (load_reg) begin
                chain_reg[ROW_W-1:0] <= row_rdata;
            end else if (tck_rise && state_reg == ST_SHDR && sel == SEL_CHAIN) begin
                chain_reg <= {tdi_s2_reg, chain_reg[CHAIN_W-1:1]};
            end
        end
    end

    // TDO changes on the falling edge and is released outside shift states
    always @(posedge clk_i) begin
        if (srst_i) begin
            tdo_o <= 1'b0;
            tdo_oe_n_o <= 1'b1;
        end else if (tck_fall) begin
            if (state_reg == ST_SHIR) begin
                tdo_o <= ir_shift_reg[0];
            end else begin
                case (sel)
                    SEL_ID: tdo_o <= id_shift_reg[0];
                    SEL_CHAIN: tdo_o <= chain_reg[0];
                    default: tdo_o <= bypass_reg;
                endcase
            end
            tdo_oe_n_o <= ~(state_reg == ST_SHIR || state_reg == ST_SHDR);
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            armed_o <= 1'b0;
            test_mode_o <= 1'b0;
        end else begin
            armed_o <= armed_reg;
            test_mode_o <= (state_reg != ST_TLR);
        end
    end

    // Cells are written and cleared from the core supply alone
    row_mem #(
        .ADDR_W(ADDR_W),
        .DATA_W(ROW_W)
    ) u_row_mem (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .clear_i(clear_reg),
        .wr_i(wr_reg),
        .rd_i(rd_reg),
        .addr_i(row_addr),
        .wdata_i(chain_reg[ROW_W-1:0]),
        .rdata_o(row_rdata)
    );
endmodule

// ---- tb/isp_tap_checker.sv ----
// Concurrent checks on the test port and status outputs
`timescale 1ns/10ps
module isp_tap_checker (
    // Clock and reset
    input wire clk_i,
    input wire srst_i,
    // Test port and status
    input wire tck_i,
    input wire tms_i,
    input wire tdo_o,
    input wire tdo_oe_n_o,
    input wire armed_o,
    input wire test_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence tck_high;
        tck_i && $past(tck_i);
    endsequence
    // Checked during reset itself, so the default disable is overridden here
    property reset_quiet;
        disable iff (1'b0) srst_i |=> tdo_oe_n_o && !armed_o && !test_mode_o;
    endproperty
    chk_reset_quiet: assert property (reset_quiet)
        else $error("outputs not quiet in reset");
    chk_tdo_fall: assert property (tck_high |-> $stable(tdo_o))
        else $error("tdo moved while tck high");
    chk_oe_fall: assert property (tck_high |-> $stable(tdo_oe_n_o))
        else $error("tdo enable moved while tck high");
    chk_oe_test: assert property (!tdo_oe_n_o |-> test_mode_o)
        else $error("tdo driven outside test mode");
    chk_arm_test: assert property ($rose(armed_o) |-> test_mode_o)
        else $error("armed outside test mode");
    chk_arm_kept: assert property (armed_o && test_mode_o |=> armed_o || !test_mode_o)
        else $error("unlock lost before test reset");
    chk_test_entry: assert property ($rose(test_mode_o) |-> !tms_i)
        else $error("test mode entered with tms high");
    chk_test_exit: assert property ($fell(test_mode_o) |-> tms_i)
        else $error("test reset with tms low");
endmodule

bind isp_tap isp_tap_checker chk (.clk_i(clk_i), .srst_i(srst_i), .tck_i(tck_i),
    .tms_i(tms_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
    .armed_o(armed_o), .test_mode_o(test_mode_o));

// ---- tb/isp_host.sv ----
// Programming controller model driving the test port pins
`timescale 1ns/10ps
module isp_host #(
    // Cells are not timed by the device, so long waits are cut to a few test clocks
    parameter INIT_CLK = 20000,
    parameter ERASE_TCK = 8,
    parameter WRITE_TCK = 4,
    parameter READ_TCK = 2
) (
    // System clock
    input wire clk_i,
    // Test port
    output reg tck_o = 1'b0,
    output reg tms_o = 1'b1,
    output reg tdi_o = 1'b1,
    input wire tdo_i
);
    reg b;
    // One 160 ns test clock; TDO is taken at the rise, half a period after it moved
    task tick(input reg tms, input reg tdi, output reg tdo);
        @(posedge clk_i);
        #1 tms_o = tms;
        tdi_o = tdi;
        repeat (15) @(posedge clk_i);
        #1 tck_o = 1'b1;
        tdo = tdo_i;
        repeat (16) @(posedge clk_i);
        #1 tck_o = 1'b0;
    endtask
    task run(input reg tms, input integer n);
        repeat (n) tick(tms, 1'b1, b);
    endtask
    // From and back to run-test-idle, LSB first, TMS high on the last bit
    task scan(input reg ir, input integer n, input reg [63:0] din, output reg [63:0] dout);
        integer k;
        dout = 64'h0;
        run(1'b1, ir ? 2 : 1);
        run(1'b0, 2);
        for (k = 0; k < n; k = k + 1) tick(k == n - 1, din[k], dout[k]);
        run(1'b1, 1);
        run(1'b0, 1);
    endtask
endmodule

// ---- tb/isp_tap_tb.sv ----
// Self-checking bench for the programming test port
`timescale 1ns/10ps
`include "isp_consts.vh"
module isp_tap_tb;
    // Arbitrary identification value with bit 0 set
    localparam [`ID_W-1:0] ID = 32'h1234_5671;
    localparam [31:0] ROW = 32'hC3A5_0F96;
    reg clk_i = 1'b0;
    reg srst_i = 1'b1;
    reg [63:0] q;
    integer fails = 0;
    integer comparisons = 0;
    wire tck, tms, tdi, tdo, tdo_oe_n, armed, test_mode;
    // A released TDO reads high through its pull-up
    wire tdo_line = tdo_oe_n ? 1'b1 : tdo;
    isp_tap #(.ID_CODE(ID)) DUT (.clk_i(clk_i), .srst_i(srst_i), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .armed_o(armed),
        .test_mode_o(test_mode));
    isp_host host (.clk_i(clk_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_line));
    initial forever #2.5 clk_i = ~clk_i;
    task check(input [63:0] got, input [63:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task ir(input [3:0] code);
        host.scan(1'b1, 4, {60'h0, code}, q);
        check(q, {60'h0, `IR_CAPTURE});
    endtask
    task row_op(input [3:0] op, input [5:0] addr, input [31:0] data, input integer w);
        ir(`OP_ENABLE);
        host.scan(1'b0, 38, {26'h0, addr, data}, q);
        ir(op);
        host.run(1'b0, w);
    endtask
    // Chain is preloaded with the inverse so a missing readback shows
    task read_row(input [5:0] addr, input [31:0] exp);
        row_op(`OP_VERIFY, addr, ~exp, host.READ_TCK);
        host.scan(1'b0, 38, 64'h0, q);
        check(q, {26'h0, addr, exp});
    endtask
    task t_identify;
        check({armed, test_mode, tdo_oe_n}, 64'h1);
        host.run(1'b0, 1);
        check(test_mode, 1'b1);
        host.scan(1'b0, 32, 64'h0, q);
        check(q, ID);
        ir(`OP_BYPASS);
        host.scan(1'b0, 8, 64'hA5, q);
        check(q, 64'h4A);
        ir(4'h6);
        host.scan(1'b0, 8, 64'hA5, q);
        check(q, 64'h4A);
    endtask
    task t_program;
        row_op(`OP_ERASE, 6'h00, 32'h0, host.ERASE_TCK);
        row_op(`OP_PROGRAM, 6'h3F, ROW, host.WRITE_TCK);
        check(armed, 1'b1);
        read_row(6'h3F, ROW);
        read_row(6'h00, 32'h0);
        host.run(1'b1, 5);
        check({armed, test_mode}, 64'h0);
        host.run(1'b0, 1);
        ir(`OP_ERASE);
        host.run(1'b0, host.ERASE_TCK);
        read_row(6'h3F, ROW);
        row_op(`OP_ERASE, 6'h01, 32'h0, host.ERASE_TCK);
        read_row(6'h3F, 32'h0);
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        #1 srst_i = 1'b0;
        repeat (host.INIT_CLK) @(posedge clk_i);
        t_identify;
        t_program;
        summarize;
    end
    initial begin
        repeat (90000) @(posedge clk_i);
        fails = fails + 1;
        summarize;
    end
endmodule
